// File: inc/tlic_pkg.sv
package tlic_pkg;

  // Bus and level sizes
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int SRC_PER_LVL = 8;
  localparam int NUM_LVL     = 3;
  localparam int NUM_SRC     = 24;

  typedef logic [ADDR_W-1:0] tlic_addr_t;
  typedef logic [DATA_W-1:0] tlic_byte_t;

  // Register offsets
  localparam tlic_addr_t OFF_FLG_HIGH = 16'h0040;
  localparam tlic_addr_t OFF_FLG_MID  = 16'h0041;
  localparam tlic_addr_t OFF_FLG_LOW  = 16'h0042;
  localparam tlic_addr_t OFF_EN_HIGH  = 16'h0043;
  localparam tlic_addr_t OFF_EN_MID   = 16'h0044;
  localparam tlic_addr_t OFF_EN_LOW   = 16'h0045;
  localparam tlic_addr_t OFF_TOP_NUM  = 16'h0046;
  localparam tlic_addr_t OFF_PEND_LVL = 16'h0047;
  localparam tlic_addr_t OFF_IRQ_STS  = 16'h0048;
  localparam tlic_addr_t OFF_IRQ_MSK  = 16'h0049;

  // Reset values and fixed codes
  localparam tlic_byte_t RST_FLAGS   = 8'h00;
  localparam tlic_byte_t RST_EN      = 8'h00;
  localparam tlic_byte_t RST_RDATA   = 8'h00;
  localparam logic [2:0] RST_STS     = 3'h0;
  localparam logic [2:0] RST_MSK     = 3'h0;
  localparam tlic_byte_t NONE_NUM    = 8'hFF;
  localparam tlic_byte_t HIGH_VALID  = 8'h7F;
  localparam tlic_byte_t BASE_HIGH   = 8'h10;
  localparam tlic_byte_t BASE_MID    = 8'h08;
  localparam tlic_byte_t BASE_LOW    = 8'h00;

  // Pending-level and status bit positions
  localparam int LVL_HIGH_POS = 2;
  localparam int LVL_MID_POS  = 1;
  localparam int LVL_LOW_POS  = 0;

  // High level source positions
  localparam int HI_TICK_POS   = 6;
  localparam int HI_SPI_POS    = 5;
  localparam int HI_COUNTER_A_SRC_POS   = 4;
  localparam int HI_COUNTER_C_SRC_POS   = 3;
  localparam int HI_CODEC_POS  = 2;
  localparam int HI_LTX_POS    = 1;
  localparam int HI_LRX_POS    = 0;

  // Middle level source positions
  localparam int MI_ATX_POS    = 7;
  localparam int MI_ARX_POS    = 6;
  localparam int MI_P5_POS     = 5;
  localparam int MI_P4_POS     = 4;
  localparam int MI_SEC_POS    = 3;
  localparam int MI_WAKE_POS   = 2;
  localparam int MI_P1_POS     = 1;
  localparam int MI_P0_POS     = 0;

  // Low level source positions
  localparam int LO_P7_POS     = 7;
  localparam int LO_P6_POS     = 6;
  localparam int LO_COUNTER_B_SRC_POS   = 5;
  localparam int LO_COUNTER_D_SRC_POS   = 4;
  localparam int LO_P3_POS     = 3;
  localparam int LO_P2_POS     = 2;
  localparam int LO_LFLOW_POS  = 1;
  localparam int LO_AFLOW_POS  = 0;

endpackage

// File: src/tlic_edge_sync.sv
`timescale 1ns/1ps
module tlic_edge_sync (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // Raw sources and detected rising edges
  input  wire logic [tlic_pkg::NUM_SRC-1:0]  raw,
  output logic      [tlic_pkg::NUM_SRC-1:0]  rise
);
  import tlic_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] s1;
    logic [NUM_SRC-1:0] s2;
    logic [NUM_SRC-1:0] s3;
  } tlic_sync_s;

  tlic_sync_s st_r;
  tlic_sync_s st_nxt;

  // Two-flop synchroniser plus one delay stage for edge detection
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // Sampled on the fastest clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Rising edge seen only on the synchronised copy
  assign rise = st_r.s2 & ~st_r.s3;

  a_edge_after_sync: assert property (@(posedge mclk) disable iff (sys_rst)
    ##3 ((rise & ~$past(raw, 2)) == '0))
    else $error("edge reported without synchronised high level");

endmodule // tlic_edge_sync

// File: src/tlic_top.sv
`timescale 1ns/1ps
// Function
// - Twenty-three sources are taken in three levels of eight bits (high bit 7 reserved), each level in one 8-bit flag register.
// - Every source passes a two-flop synchroniser on the system clock before edge detection.
// - A set flag raises and holds the processor line of its own level, one line per level.
// - A flag is set only by a rising edge while its enable bit is one.
// - Writing one to a flag bit clears it and writing zero leaves it alone.
// - Reset clears every flag and every enable bit.
// - The top number register shows the highest set flag and reads FF when none is set.
// - The pending-level register shows high, middle and low activity on bits 2, 1 and 0.
// - The high register maps tick, serial port, counters A and C, codec and link serial tx and rx.
// - The middle register maps app serial tx and rx, port bits 5 and 4, second tick, wake-up, bits 1 and 0.
// - The low register maps port bits 7 and 6, counters B and D, port bits 3 and 2 and both flow controls.
// - Each enable register holds one bit per source at the flag position and resets to zero.
module tlic_top (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Register port
  input  wire tlic_pkg::tlic_addr_t  addr,
  input  wire tlic_pkg::tlic_byte_t  wr_data,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output tlic_pkg::tlic_byte_t       rd_data,
  // High level sources
  input  wire logic                  slow_tick_fast_src,
  input  wire logic                  spi_src,
  input  wire logic                  counter_a_src,
  input  wire logic                  counter_c_src,
  input  wire logic                  codec_src,
  input  wire logic                  link_serial_tx_src,
  input  wire logic                  link_serial_rx_src,
  // Middle level sources
  input  wire logic                  app_serial_tx_src,
  input  wire logic                  app_serial_rx_src,
  input  wire logic                  in_port_bit5_src,
  input  wire logic                  in_port_bit4_src,
  input  wire logic                  second_tick_src,
  input  wire logic                  wakeup_src,
  input  wire logic                  in_port_bit1_src,
  input  wire logic                  in_port_bit0_src,
  // Low level sources
  input  wire logic                  in_port_bit7_src,
  input  wire logic                  in_port_bit6_src,
  input  wire logic                  counter_b_src,
  input  wire logic                  counter_d_src,
  input  wire logic                  in_port_bit3_src,
  input  wire logic                  in_port_bit2_src,
  input  wire logic                  link_serial_flow_src,
  input  wire logic                  app_serial_flow_src,
  // Processor lines and summary interrupt
  output logic                       cpu_line_high,
  output logic                       cpu_line_middle,
  output logic                       cpu_line_low,
  output logic                       irq
);
  import tlic_pkg::*;

  typedef struct packed {
    tlic_byte_t flg_h;
    tlic_byte_t flg_m;
    tlic_byte_t flg_l;
    tlic_byte_t en_h;
    tlic_byte_t en_m;
    tlic_byte_t en_l;
    logic [2:0] sts;
    logic [2:0] msk;
    tlic_byte_t rdat;
    logic       line_h;
    logic       line_m;
    logic       line_l;
    logic       irq;
  } tlic_state_s;

  localparam tlic_state_s ST_RST = '{
    flg_h: RST_FLAGS, flg_m: RST_FLAGS, flg_l: RST_FLAGS,
    en_h: RST_EN, en_m: RST_EN, en_l: RST_EN,
    sts: RST_STS, msk: RST_MSK, rdat: RST_RDATA,
    line_h: 1'b0, line_m: 1'b0, line_l: 1'b0, irq: 1'b0};

  tlic_state_s st_r;
  tlic_state_s st_nxt;

  tlic_byte_t         raw_h;
  tlic_byte_t         raw_m;
  tlic_byte_t         raw_l;
  logic [NUM_SRC-1:0] rise;
  tlic_byte_t         rise_h;
  tlic_byte_t         rise_m;
  tlic_byte_t         rise_l;
  tlic_byte_t         top_num;
  tlic_byte_t         pend_lvl;

  // Index of the highest set bit in one level
  function automatic logic [2:0] tlic_msb(input tlic_byte_t v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < SRC_PER_LVL; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Top pending number from three flag sets
  function automatic tlic_byte_t tlic_top_num(input tlic_byte_t h,
                                              input tlic_byte_t m,
                                              input tlic_byte_t l);
    tlic_byte_t r;
    r = NONE_NUM;
    if (|h) begin
      r = BASE_HIGH + {5'h00, tlic_msb(h)};
    end else if (|m) begin
      r = BASE_MID + {5'h00, tlic_msb(m)};
    end else if (|l) begin
      r = BASE_LOW + {5'h00, tlic_msb(l)};
    end
    return r;
  endfunction

  // Source placement in the high level register
  always_comb begin
    raw_h              = 8'h00; // Reserved bit 7 stays low
    raw_h[HI_TICK_POS]  = slow_tick_fast_src;
    raw_h[HI_SPI_POS]   = spi_src;
    raw_h[HI_COUNTER_A_SRC_POS]  = counter_a_src;
    raw_h[HI_COUNTER_C_SRC_POS]  = counter_c_src;
    raw_h[HI_CODEC_POS] = codec_src;
    raw_h[HI_LTX_POS]   = link_serial_tx_src;
    raw_h[HI_LRX_POS]   = link_serial_rx_src;
  end

  // Source placement in the middle level register
  always_comb begin
    raw_m              = 8'h00;
    raw_m[MI_ATX_POS]  = app_serial_tx_src;
    raw_m[MI_ARX_POS]  = app_serial_rx_src;
    raw_m[MI_P5_POS]   = in_port_bit5_src;
    raw_m[MI_P4_POS]   = in_port_bit4_src;
    raw_m[MI_SEC_POS]  = second_tick_src;
    raw_m[MI_WAKE_POS] = wakeup_src;
    raw_m[MI_P1_POS]   = in_port_bit1_src;
    raw_m[MI_P0_POS]   = in_port_bit0_src;
  end

  // Source placement in the low level register
  always_comb begin
    raw_l               = 8'h00;
    raw_l[LO_P7_POS]    = in_port_bit7_src;
    raw_l[LO_P6_POS]    = in_port_bit6_src;
    raw_l[LO_COUNTER_B_SRC_POS]  = counter_b_src;
    raw_l[LO_COUNTER_D_SRC_POS]  = counter_d_src;
    raw_l[LO_P3_POS]    = in_port_bit3_src;
    raw_l[LO_P2_POS]    = in_port_bit2_src;
    raw_l[LO_LFLOW_POS] = link_serial_flow_src;
    raw_l[LO_AFLOW_POS] = app_serial_flow_src;
  end

  // Synchronise and edge-detect all 24 source bits
  tlic_edge_sync u_edge (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .raw     ({raw_l, raw_m, raw_h}),
    .rise    (rise)
  );

  // Split edges back into levels
  assign rise_h = rise[7:0] & HIGH_VALID;
  assign rise_m = rise[15:8];
  assign rise_l = rise[23:16];

  // Read-only views of the current flags
  assign top_num  = tlic_top_num(st_r.flg_h, st_r.flg_m, st_r.flg_l);
  assign pend_lvl = {5'h00, |st_r.flg_h, |st_r.flg_m, |st_r.flg_l};

  // Next state: flags, enables, status, read data, lines
  always_comb begin
    logic [2:0] sts_set;
    logic [2:0] sts_clr;
    tlic_byte_t clr_h;
    tlic_byte_t clr_m;
    tlic_byte_t clr_l;
    tlic_byte_t set_h;
    tlic_byte_t set_m;
    tlic_byte_t set_l;
    sts_set = 3'h0;
    sts_clr = 3'h0;
    clr_h   = 8'h00;
    clr_m   = 8'h00;
    clr_l   = 8'h00;
    set_h   = 8'h00;
    set_m   = 8'h00;
    set_l   = 8'h00;
    st_nxt  = st_r;

    // Write one to clear a flag
    if (wr_en && addr == OFF_FLG_HIGH) clr_h = wr_data;
    if (wr_en && addr == OFF_FLG_MID)  clr_m = wr_data;
    if (wr_en && addr == OFF_FLG_LOW)  clr_l = wr_data;

    // Enable and mask registers, status clear
    if (wr_en && addr == OFF_EN_HIGH) st_nxt.en_h = wr_data & HIGH_VALID;
    if (wr_en && addr == OFF_EN_MID)  st_nxt.en_m = wr_data;
    if (wr_en && addr == OFF_EN_LOW)  st_nxt.en_l = wr_data;
    if (wr_en && addr == OFF_IRQ_MSK) st_nxt.msk  = wr_data[2:0];
    if (wr_en && addr == OFF_IRQ_STS) sts_clr     = wr_data[2:0];

    // Edge sets a flag only when enabled; set beats clear
    set_h = rise_h & st_r.en_h;
    set_m = rise_m & st_r.en_m;
    set_l = rise_l & st_r.en_l;
    st_nxt.flg_h = ((st_r.flg_h & ~clr_h) | set_h) & HIGH_VALID;
    st_nxt.flg_m = (st_r.flg_m & ~clr_m) | set_m;
    st_nxt.flg_l = (st_r.flg_l & ~clr_l) | set_l;

    // Sticky per-level event status, set beats clear
    sts_set[LVL_HIGH_POS] = |set_h;
    sts_set[LVL_MID_POS]  = |set_m;
    sts_set[LVL_LOW_POS]  = |set_l;
    st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;

    // Processor lines held while any flag of the level is set
    st_nxt.line_h = |st_nxt.flg_h;
    st_nxt.line_m = |st_nxt.flg_m;
    st_nxt.line_l = |st_nxt.flg_l;
    st_nxt.irq    = |(st_nxt.sts & st_nxt.msk);

    // Read data valid in the cycle after the strobe only
    st_nxt.rdat = 8'h00;
    if (rd_en) begin
      unique case (addr)
        OFF_FLG_HIGH: st_nxt.rdat = st_r.flg_h;
        OFF_FLG_MID:  st_nxt.rdat = st_r.flg_m;
        OFF_FLG_LOW:  st_nxt.rdat = st_r.flg_l;
        OFF_EN_HIGH:  st_nxt.rdat = st_r.en_h;
        OFF_EN_MID:   st_nxt.rdat = st_r.en_m;
        OFF_EN_LOW:   st_nxt.rdat = st_r.en_l;
        OFF_TOP_NUM:  st_nxt.rdat = top_num;
        OFF_PEND_LVL: st_nxt.rdat = pend_lvl;
        OFF_IRQ_STS:  st_nxt.rdat = {5'h00, st_r.sts};
        OFF_IRQ_MSK:  st_nxt.rdat = {5'h00, st_r.msk};
        default:      st_nxt.rdat = 8'h00;
      endcase
    end
  end

  // State register, synchronous reset clears flags and enables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign rd_data         = st_r.rdat;
  assign cpu_line_high   = st_r.line_h;
  assign cpu_line_middle = st_r.line_m;
  assign cpu_line_low    = st_r.line_l;
  assign irq             = st_r.irq;

  // Checks
  a_flag_needs_en: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 (((st_r.flg_m & ~$past(st_r.flg_m)) & ~$past(st_r.en_m)) == 8'h00))
    else $error("middle flag set while disabled");

  a_w1c_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_en && addr == OFF_FLG_LOW) |=> ((st_r.flg_l & $past(wr_data) & ~$past(rise_l)) == 8'h00))
    else $error("low flag survived a one write");

  a_w0_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_en && addr == OFF_FLG_MID) |=> ((~$past(wr_data) & $past(st_r.flg_m) & ~st_r.flg_m) == 8'h00))
    else $error("middle flag lost on a zero write");

  a_reset_clear: assert property (@(posedge mclk)
    sys_rst |=> (st_r.flg_h == 8'h00 && st_r.flg_m == 8'h00 && st_r.flg_l == 8'h00 &&
                 st_r.en_h == 8'h00 && st_r.en_m == 8'h00 && st_r.en_l == 8'h00))
    else $error("flags or enables not cleared by reset");

  a_line_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    (cpu_line_high == (|st_r.flg_h)) && (cpu_line_low == (|st_r.flg_l)))
    else $error("processor line disagrees with its flags");

  a_none_reads_ff: assert property (@(posedge mclk) disable iff (sys_rst)
    (rd_en && addr == OFF_TOP_NUM && {st_r.flg_h, st_r.flg_m, st_r.flg_l} == 24'h000000)
    |=> rd_data == 8'hFF)
    else $error("top number not FF with nothing pending");

  a_high_outranks: assert property (@(posedge mclk) disable iff (sys_rst)
    (|st_r.flg_h) |-> (top_num[7:3] == 5'h02 && st_r.flg_h[top_num[2:0]]))
    else $error("high level flag not reported first");

  a_mid_order: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.flg_h == 8'h00 && |st_r.flg_m) |->
      (top_num[7:3] == 5'h01 && (st_r.flg_m >> top_num[2:0]) == 8'h01))
    else $error("middle level order wrong");

  a_pend_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (rd_en && addr == OFF_PEND_LVL) |=>
      rd_data == {5'h00, $past(|st_r.flg_h), $past(|st_r.flg_m), $past(|st_r.flg_l)})
    else $error("pending level read wrong");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.flg_h[7] == 1'b0 && st_r.en_h[7] == 1'b0)
    else $error("reserved high bit set");

  a_enable_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_en && addr == OFF_EN_LOW) |=> st_r.en_l == $past(wr_data))
    else $error("low enable not written");

  a_edge_to_line: assert property (@(posedge mclk) disable iff (sys_rst)
    (|(rise_m & st_r.en_m)) |=> cpu_line_middle)
    else $error("enabled middle edge did not raise line");

  a_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_en && addr == OFF_FLG_HIGH) |=>
      ((($past(rise_h) & $past(st_r.en_h)) & ~st_r.flg_h) == 8'h00))
    else $error("high edge lost against a same cycle clear");

  a_low_edge_sets: assert property (@(posedge mclk) disable iff (sys_rst)
    (|(rise_l & st_r.en_l)) |=>
      ((($past(rise_l) & $past(st_r.en_l)) & ~st_r.flg_l) == 8'h00))
    else $error("enabled low edge did not set its flag");

  a_line_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    (cpu_line_high && !(wr_en && addr == OFF_FLG_HIGH)) |=> cpu_line_high)
    else $error("high line dropped without a clear");

  a_top_none: assert property (@(posedge mclk) disable iff (sys_rst)
    ({st_r.flg_h, st_r.flg_m, st_r.flg_l} == 24'h000000) |-> (top_num == NONE_NUM))
    else $error("top number not FF with no flag");

  a_low_order: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.flg_h == 8'h00 && st_r.flg_m == 8'h00 && |st_r.flg_l) |->
      (top_num[7:3] == 5'h00 && (st_r.flg_l >> top_num[2:0]) == 8'h01))
    else $error("low level order wrong");

  a_en_high_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_en && addr == OFF_EN_HIGH) |=> st_r.en_h == ($past(wr_data) & HIGH_VALID))
    else $error("high enable not written");

  a_reset_idle: assert property (@(posedge mclk)
    sys_rst |=> (top_num == NONE_NUM && !cpu_line_high && !cpu_line_middle && !cpu_line_low))
    else $error("lines or top number not idle after reset");

endmodule // tlic_top

// File: verification/tlic_cpu_model.sv
`timescale 1ns/1ps
// Processor side: one core pending bit per line, retired by the service routine
module tlic_cpu_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Lines from the controller, high on bit 2
  input  wire logic [2:0] line,
  // Service acknowledge and core pending bits
  input  wire logic [2:0] ack,
  output logic      [2:0] core_pend_r
);
  logic [2:0] line_r;

  // Core status: set on a rising line, kept until software clears it here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      line_r      <= 3'h0;
      core_pend_r <= 3'h0;
    end else begin
      line_r      <= line;
      core_pend_r <= (core_pend_r & ~ack) | (line & ~line_r);
    end
  end
endmodule // tlic_cpu_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tlic_pkg::*;
  logic        mclk;
  logic        sys_rst;
  tlic_addr_t  addr;
  tlic_byte_t  wr_data;
  logic        wr_en;
  logic        rd_en;
  wire tlic_byte_t rd_data;
  logic [23:0] src;
  wire  [2:0]  line;
  wire         irq;
  logic [2:0]  ack;
  wire  [2:0]  core_pend;
  logic        rd_d = 1'b0;
  tlic_byte_t  exp_q[$];
  int          fail_count;
  int          n_checks;
  int          cycles;
  logic [31:0] lf;
  logic [23:0] en;
  logic [23:0] sv;
  logic [23:0] f;
  logic [2:0]  mk;
  logic [2:0]  lv;
  tlic_byte_t  c;

  // Device under test, source bit n of level L on src[8*L+n]
  tlic_top DUT (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .addr                 (addr),
    .wr_data              (wr_data),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rd_data              (rd_data),
    .slow_tick_fast_src   (src[22]),
    .spi_src              (src[21]),
    .counter_a_src        (src[20]),
    .counter_c_src        (src[19]),
    .codec_src            (src[18]),
    .link_serial_tx_src   (src[17]),
    .link_serial_rx_src   (src[16]),
    .app_serial_tx_src    (src[15]),
    .app_serial_rx_src    (src[14]),
    .in_port_bit5_src     (src[13]),
    .in_port_bit4_src     (src[12]),
    .second_tick_src      (src[11]),
    .wakeup_src           (src[10]),
    .in_port_bit1_src     (src[9]),
    .in_port_bit0_src     (src[8]),
    .in_port_bit7_src     (src[7]),
    .in_port_bit6_src     (src[6]),
    .counter_b_src        (src[5]),
    .counter_d_src        (src[4]),
    .in_port_bit3_src     (src[3]),
    .in_port_bit2_src     (src[2]),
    .link_serial_flow_src (src[1]),
    .app_serial_flow_src  (src[0]),
    .cpu_line_high        (line[2]),
    .cpu_line_middle      (line[1]),
    .cpu_line_low         (line[0]),
    .irq                  (irq)
  );

  // Processor core partner
  tlic_cpu_model CORE (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .line        (line),
    .ack         (ack),
    .core_pend_r (core_pend)
  );

  // Clock generation
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Comparison with report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bus cycles, entered just after a rising edge
  task automatic wr(input tlic_addr_t a, input tlic_byte_t d);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wr_data <= d;
    @(posedge mclk);
  endtask

  task automatic rd(input tlic_addr_t a, input tlic_byte_t e);
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
  endtask

  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // Random source from a shift register
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    end
    return lf;
  endfunction

  // Highest set flag number, later bits overriding earlier ones
  function automatic tlic_byte_t top_of(input logic [23:0] fl);
    top_of = NONE_NUM;
    for (int i = 0; i < 24; i++) begin
      if (fl[i]) begin
        top_of = (i >= 16) ? BASE_HIGH + 8'(i - 16) :
                 (i >= 8) ? BASE_MID + 8'(i - 8) : BASE_LOW + 8'(i);
      end
    end
  endfunction

  // Reset values of every register and of an unmapped place
  task automatic reset_reads();
    for (int i = 0; i < 10; i++) begin
      rd(OFF_FLG_HIGH + 16'(i), (i == 6) ? NONE_NUM : 8'h00);
    end
    rd(16'h0140, 8'h00);
    idle(2);
    chk("lines", 8'h00, {5'h0, line});
  endtask

  // Read monitor: data stand in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_d) begin
      chk("rd_data", exp_q.pop_front(), rd_data);
    end
    rd_d <= rd_en;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    src = 24'h000000;
    ack = 3'h0;
    fail_count = 0;
    n_checks = 0;
    lf = 32'h6e49a2dd;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    reset_reads();
    // Access kinds, read-only and unmapped places
    wr(OFF_EN_HIGH, 8'hFF);
    rd(OFF_EN_HIGH, HIGH_VALID);
    wr(OFF_TOP_NUM, 8'h00);
    rd(OFF_TOP_NUM, NONE_NUM);
    wr(OFF_PEND_LVL, 8'hFF);
    rd(OFF_PEND_LVL, 8'h00);
    wr(16'h0140, 8'hFF);
    rd(16'h0140, 8'h00);
    // Edges while disabled are lost, a held level sets nothing later
    wr(OFF_EN_HIGH, 8'h00);
    src <= 24'h7FFFFF;
    idle(6);
    wr(OFF_EN_HIGH, 8'hFF);
    wr(OFF_EN_MID, 8'hFF);
    wr(OFF_EN_LOW, 8'hFF);
    idle(6);
    rd(OFF_FLG_HIGH, 8'h00);
    rd(OFF_FLG_MID, 8'h00);
    rd(OFF_FLG_LOW, 8'h00);
    src <= 24'h000000;
    idle(3);
    // Random enables, sources and masks
    for (int k = 0; k < 40; k++) begin
      en = 24'(rnd());
      sv = 24'(rnd());
      mk = 3'(rnd());
      c = 8'(rnd());
      wr(OFF_EN_HIGH, en[23:16]);
      wr(OFF_EN_MID, en[15:8]);
      wr(OFF_EN_LOW, en[7:0]);
      wr(OFF_IRQ_MSK, {5'h0, mk});
      src <= sv;
      idle(5);
      f = sv & en & 24'h7FFFFF;
      lv = {|f[23:16], |f[15:8], |f[7:0]};
      rd(OFF_FLG_HIGH, f[23:16]);
      rd(OFF_FLG_MID, f[15:8]);
      rd(OFF_FLG_LOW, f[7:0]);
      rd(OFF_TOP_NUM, top_of(f));
      rd(OFF_PEND_LVL, {5'h0, lv});
      rd(OFF_IRQ_STS, {5'h0, lv});
      idle(1);
      chk("lines", {5'h0, lv}, {5'h0, line});
      chk("irq", {7'h0, |(lv & mk)}, {7'h0, irq});
      chk("core_pend", {5'h0, lv}, {5'h0, core_pend});
      // Partial clear with sources still held high
      wr(OFF_FLG_MID, c);
      wr(OFF_FLG_HIGH, 8'h00);
      rd(OFF_FLG_MID, f[15:8] & ~c);
      rd(OFF_FLG_HIGH, f[23:16]);
      wr(OFF_FLG_HIGH, 8'hFF);
      wr(OFF_FLG_MID, 8'hFF);
      wr(OFF_FLG_LOW, 8'hFF);
      wr(OFF_IRQ_STS, 8'h07);
      rd(OFF_TOP_NUM, NONE_NUM);
      rd(OFF_PEND_LVL, 8'h00);
      idle(1);
      chk("lines", 8'h00, {5'h0, line});
      chk("irq", 8'h00, {7'h0, irq});
      chk("core_pend", {5'h0, lv}, {5'h0, core_pend});
      ack <= 3'h7;
      idle(1);
      ack <= 3'h0;
      src <= 24'h000000;
      idle(2);
      chk("core_pend", 8'h00, {5'h0, core_pend});
    end
    // Edge and clear in one cycle: the set wins
    wr(OFF_EN_HIGH, 8'hFF);
    src <= 24'h400000;
    idle(2);
    wr(OFF_FLG_HIGH, 8'hFF);
    rd(OFF_FLG_HIGH, 8'h40);
    wr(OFF_FLG_HIGH, 8'hFF);
    src <= 24'h000000;
    // Reset in mid-run with flags latched
    wr(OFF_EN_HIGH, 8'hFF);
    wr(OFF_EN_MID, 8'hFF);
    wr(OFF_EN_LOW, 8'hFF);
    src <= 24'h7FFFFF;
    idle(5);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    idle(1);
    reset_reads();
    src <= 24'h000000;
    idle(3);
    give_verdict();
  end
endmodule // testbench
